// File: hdl/pldc_pkg.sv
// Package of register map, field layout, tables and types for the lock detect block
package pldc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] PLDC_IDX_WIN_WIDTH  = 10'h002;
  localparam logic [9:0] PLDC_IDX_BLEED_LO   = 10'h01D;
  localparam logic [9:0] PLDC_IDX_BLEED_HI   = 10'h01E;
  localparam logic [9:0] PLDC_IDX_PUMP_CUR   = 10'h01F;
  localparam logic [9:0] PLDC_IDX_REF_DIV    = 10'h020;
  localparam logic [9:0] PLDC_IDX_LOCK_COUNT = 10'h02C;
  localparam logic [9:0] PLDC_IDX_LOCK_EN    = 10'h02D;
  localparam logic [9:0] PLDC_IDX_TEST_OUT   = 10'h02E;
  localparam logic [9:0] PLDC_IDX_REF_COND   = 10'h02F;
  localparam logic [9:0] PLDC_IDX_STATUS     = 10'h058;

  // Field positions
  localparam int PLDC_WIN_LSB      = 5;
  localparam int PLDC_LOL_EN_BIT   = 5;
  localparam int PLDC_WIN_EN_BIT   = 4;
  localparam int PLDC_DBL_BIT      = 6;
  localparam int PLDC_BLEED_EN_BIT = 5;
  localparam int PLDC_OFFSET_CURRENT_POLARITY_BIT = 6;
  localparam int PLDC_TEST_EN_BIT  = 2;
  localparam int PLDC_FORCE_SRC_BIT = 1;
  localparam int PLDC_FORCE_SNK_BIT = 0;
  localparam int PLDC_MUX_LSB      = 4;
  localparam int PLDC_LPF_BIT      = 6;
  localparam int PLDC_BOOST_BIT    = 7;
  localparam int PLDC_ST_LOCK_BIT  = 0;
  localparam int PLDC_ST_REFOK_BIT = 3;
  localparam int PLDC_BLEED_FINE_W = 9;

  localparam logic [7:0] PLDC_REG_RST     = 8'h00;
  localparam logic [3:0] PLDC_MUX_LOCK    = 4'h1;
  localparam logic [5:0] PLDC_RDIV_MIN    = 6'h01;

  // Detector cycles per count select code, code 31 first
  localparam logic [31:0][20:0] PLDC_LOCK_CYCLES_DEF = {
    21'h10_0003, 21'h0B_FFA9, 21'h08_0003, 21'h06_0003,
    21'h04_0003, 21'h03_0003, 21'h02_0003, 21'h01_8003,
    21'h01_0003, 21'h00_C003, 21'h00_8003, 21'h00_6003,
    21'h00_4003, 21'h00_3003, 21'h00_2003, 21'h00_1803,
    21'h00_1003, 21'h00_0C03, 21'h00_0803, 21'h00_0603,
    21'h00_0403, 21'h00_0303, 21'h00_0203, 21'h00_0183,
    21'h00_0103, 21'h00_00C3, 21'h00_0083, 21'h00_0063,
    21'h00_0043, 21'h00_0033, 21'h00_0023, 21'h00_001B};

  // Lock window in core clock cycles per width code, code 7 first
  localparam logic [7:0][7:0] PLDC_WIN_CYCLES_DEF = {
    8'h10, 8'h0C, 8'h08, 8'h06, 8'h04, 8'h03, 8'h02, 8'h01};

  typedef enum logic [1:0] {
    PLDC_PUMP_NORMAL = 2'b00,
    PLDC_PUMP_HIZ    = 2'b01,
    PLDC_PUMP_SOURCE = 2'b10,
    PLDC_PUMP_SINK   = 2'b11
  } pldc_pump_mode_e;

  typedef enum logic [1:0] {
    PLDC_PH_IDLE     = 2'b00,
    PLDC_PH_REF_LEAD = 2'b01,
    PLDC_PH_FB_LEAD  = 2'b10,
    PLDC_PH_OVER     = 2'b11
  } pldc_phase_e;

  typedef struct packed {
    pldc_pump_mode_e mode;
    logic [3:0]      current_code;
    logic            bleed_enable;
    logic            offset_current_polarity;
    logic [3:0]      bleed_coarse;
    logic [8:0]      bleed_fine;
  } pldc_pump_s;

  typedef struct packed {
    logic       ref_doubler_enable;
    logic [5:0] ref_divide_ratio;
    logic       ref_lowpass_select;
    logic       ref_gain_boost;
  } pldc_ref_s;

endpackage

// File: hdl/pldc_lock_detect.sv
// Lock detector, reference status and pump control registers behind APB
// Functional notes
// - Detector runs only with both enables set
// - Lock drives indicator pin and status bit 0
// - Test output select 0001 routes lock out
// - Lock needs selected count of in-window cycles
// - Count select picks cycles from fixed table
// - In window, below count: low, keep counting
// - High at count; drops at once outside window
// - Width field sets phase-difference threshold
// - Reference present flag with hysteresis, bit 3
// - Doubler enable doubles divider input frequency
// - Six-bit divide ratio, valid 1 to 63
// - Four-bit pump current code, sixteen levels
// - Pump test: high-Z, source or sink forcing
// - Bleed enable adds current; polarity picks direction
// - Bleed code: 4 coarse, 9 fine bits
// - Bleed code low byte, then upper five bits
`timescale 1ns/10ps
module pldc_lock_detect
  import pldc_pkg::*;
#(
  parameter logic [31:0][20:0] LOCK_CYCLES_TAB = PLDC_LOCK_CYCLES_DEF,
  parameter logic [7:0][7:0]   WIN_CYCLES_TAB  = PLDC_WIN_CYCLES_DEF
)(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ref_side_clock,
  input  wire logic        feedback_side_clock,
  input  wire logic        ref_peak_above_high,
  input  wire logic        ref_peak_above_low,
  output logic             lock_indicator_pin,
  output logic             test_output_pin,
  output pldc_pump_s       pump_ctrl,
  output pldc_ref_s        ref_ctrl
);

  logic [7:0]  win_width_q;
  logic [7:0]  bleed_lo_q;
  logic [7:0]  bleed_hi_q;
  logic [7:0]  pump_cur_q;
  logic [7:0]  ref_div_q;
  logic [7:0]  lock_count_q;
  logic [7:0]  lock_en_q;
  logic [7:0]  test_out_q;
  logic [7:0]  ref_cond_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [1:0]  edge_hist_q;
  logic        ref_edge;
  logic        fb_edge;
  pldc_phase_e ph_state_q;
  pldc_phase_e ph_state_d;
  logic [7:0]  ph_cnt_q;
  logic [7:0]  win_cycles;
  logic        good_cycle;
  logic        bad_cycle;
  logic        det_enable;
  logic [20:0] lock_target;
  logic [20:0] lock_cnt_q;
  logic        lock_q;
  logic        ref_ok_q;
  logic        mux_out_q;
  logic        apb_write;
  logic [9:0]  reg_idx;
  logic        idx_hit;
  logic [7:0]  rd_byte;
  logic [12:0] bleed_code;

  // Access stage answers at once; pready never low
  assign pready    = 1'b1;
  assign reg_idx   = paddr[11:2];
  assign apb_write = psel & penable & pwrite & pstrb[0] & idx_hit;
  assign pslverr   = psel & penable & (~idx_hit | (pwrite & (reg_idx == PLDC_IDX_STATUS)));

  always_comb
  begin
    idx_hit = paddr[1:0] == 2'b00;
    rd_byte = 8'h00;
    case (reg_idx)
      PLDC_IDX_WIN_WIDTH:  rd_byte = win_width_q;
      PLDC_IDX_BLEED_LO:   rd_byte = bleed_lo_q;
      PLDC_IDX_BLEED_HI:   rd_byte = bleed_hi_q;
      PLDC_IDX_PUMP_CUR:   rd_byte = pump_cur_q;
      PLDC_IDX_REF_DIV:    rd_byte = ref_div_q;
      PLDC_IDX_LOCK_COUNT: rd_byte = lock_count_q;
      PLDC_IDX_LOCK_EN:    rd_byte = lock_en_q;
      PLDC_IDX_TEST_OUT:   rd_byte = test_out_q;
      PLDC_IDX_REF_COND:   rd_byte = ref_cond_q;
      PLDC_IDX_STATUS:
      begin
        rd_byte[PLDC_ST_LOCK_BIT]  = lock_q;
        rd_byte[PLDC_ST_REFOK_BIT] = ref_ok_q;
      end
      default:             idx_hit = 1'b0;
    endcase
  end

  assign prdata = {24'h00_0000, rd_byte};

  // Only the low byte lane carries register data
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      win_width_q  <= PLDC_REG_RST;
      bleed_lo_q   <= PLDC_REG_RST;
      bleed_hi_q   <= PLDC_REG_RST;
      pump_cur_q   <= PLDC_REG_RST;
      ref_div_q    <= PLDC_REG_RST;
      lock_count_q <= PLDC_REG_RST;
      lock_en_q    <= PLDC_REG_RST;
      test_out_q   <= PLDC_REG_RST;
      ref_cond_q   <= PLDC_REG_RST;
    end
    else if (apb_write)
    begin
      case (reg_idx)
        PLDC_IDX_WIN_WIDTH:  win_width_q  <= pwdata[7:0];
        PLDC_IDX_BLEED_LO:   bleed_lo_q   <= pwdata[7:0];
        PLDC_IDX_BLEED_HI:   bleed_hi_q   <= pwdata[7:0];
        PLDC_IDX_PUMP_CUR:   pump_cur_q   <= pwdata[7:0];
        PLDC_IDX_REF_DIV:    ref_div_q    <= pwdata[7:0];
        PLDC_IDX_LOCK_COUNT: lock_count_q <= pwdata[7:0];
        PLDC_IDX_LOCK_EN:    lock_en_q    <= pwdata[7:0];
        PLDC_IDX_TEST_OUT:   test_out_q   <= pwdata[7:0];
        PLDC_IDX_REF_COND:   ref_cond_q   <= pwdata[7:0];
        default:             lock_en_q    <= lock_en_q;
      endcase
    end
  end

  // Two-stage synchronisers for clocks and peak comparators
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    logic raw;
    if (i == 0)
    begin : g_r
      assign raw = ref_side_clock;
    end
    else if (i == 1)
    begin : g_f
      assign raw = feedback_side_clock;
    end
    else if (i == 2)
    begin : g_h
      assign raw = ref_peak_above_high;
    end
    else
    begin : g_l
      assign raw = ref_peak_above_low;
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end
      else
      begin
        sync1_q[i] <= raw;
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      edge_hist_q <= 2'b00;
    else
      edge_hist_q <= sync2_q[1:0];
  end

  assign ref_edge   = sync2_q[0] & ~edge_hist_q[0];
  assign fb_edge    = sync2_q[1] & ~edge_hist_q[1];
  assign win_cycles = WIN_CYCLES_TAB[win_width_q[PLDC_WIN_LSB +: 3]];
  assign det_enable = lock_en_q[PLDC_LOL_EN_BIT] & lock_en_q[PLDC_WIN_EN_BIT];
  assign lock_target = LOCK_CYCLES_TAB[lock_count_q[4:0]];

  // Phase difference measured as core cycles between paired edges;
  // finer differences than one core cycle read as zero
  always_comb
  begin
    ph_state_d = ph_state_q;
    good_cycle = 1'b0;
    bad_cycle  = 1'b0;
    case (ph_state_q)
      PLDC_PH_IDLE:
      begin
        if (ref_edge & fb_edge)
          good_cycle = 1'b1;
        else if (ref_edge)
          ph_state_d = PLDC_PH_REF_LEAD;
        else if (fb_edge)
          ph_state_d = PLDC_PH_FB_LEAD;
      end
      PLDC_PH_REF_LEAD, PLDC_PH_FB_LEAD:
      begin
        if (ph_cnt_q >= win_cycles)
        begin
          bad_cycle  = 1'b1;
          ph_state_d = PLDC_PH_OVER;
        end
        else if ((ph_state_q == PLDC_PH_REF_LEAD) ? fb_edge : ref_edge)
        begin
          good_cycle = 1'b1;
          ph_state_d = PLDC_PH_IDLE;
        end
        else if ((ph_state_q == PLDC_PH_REF_LEAD) ? ref_edge : fb_edge)
        begin
          bad_cycle  = 1'b1;
          ph_state_d = PLDC_PH_IDLE;
        end
      end
      PLDC_PH_OVER:
      begin
        // Resynchronise once both clocks are low
        if (!sync2_q[0] && !sync2_q[1])
          ph_state_d = PLDC_PH_IDLE;
      end
      default:
        ph_state_d = PLDC_PH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_state_q <= PLDC_PH_IDLE;
      ph_cnt_q   <= 8'h00;
    end
    else
    begin
      ph_state_q <= ph_state_d;
      if (ph_state_d == PLDC_PH_REF_LEAD || ph_state_d == PLDC_PH_FB_LEAD)
        ph_cnt_q <= (ph_state_q == PLDC_PH_IDLE) ? 8'h01 : 8'(ph_cnt_q + 8'h01);
      else
        ph_cnt_q <= 8'h00;
    end
  end

  // Cycle counter and lock flag
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_cnt_q <= 21'h00_0000;
      lock_q     <= 1'b0;
    end
    else if (!det_enable)
    begin
      lock_cnt_q <= 21'h00_0000;
      lock_q     <= 1'b0;
    end
    else if (bad_cycle)
    begin
      lock_cnt_q <= 21'h00_0000;
      lock_q     <= 1'b0;
    end
    else if (good_cycle && !lock_q)
    begin
      lock_cnt_q <= 21'(lock_cnt_q + 21'h00_0001);
      lock_q     <= (21'(lock_cnt_q + 21'h00_0001) >= lock_target);
    end
  end

  // Hysteresis: set on high comparator, clear only below low one
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ref_ok_q <= 1'b0;
    else if (sync2_q[2])
      ref_ok_q <= 1'b1;
    else if (!sync2_q[3])
      ref_ok_q <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      mux_out_q <= 1'b0;
    else
      mux_out_q <= (test_out_q[PLDC_MUX_LSB +: 4] == PLDC_MUX_LOCK) & lock_q;
  end

  assign lock_indicator_pin = lock_q;
  assign test_output_pin    = mux_out_q;
  assign bleed_code         = {bleed_hi_q[4:0], bleed_lo_q};

  // Both force bits set is treated as high impedance to avoid a fight
  always_comb
  begin
    pump_ctrl.mode = PLDC_PUMP_NORMAL;
    if (test_out_q[PLDC_TEST_EN_BIT])
    begin
      case ({test_out_q[PLDC_FORCE_SRC_BIT], test_out_q[PLDC_FORCE_SNK_BIT]})
        2'b10:   pump_ctrl.mode = PLDC_PUMP_SOURCE;
        2'b01:   pump_ctrl.mode = PLDC_PUMP_SINK;
        default: pump_ctrl.mode = PLDC_PUMP_HIZ;
      endcase
    end
    pump_ctrl.current_code            = pump_cur_q[3:0];
    pump_ctrl.bleed_enable            = bleed_hi_q[PLDC_BLEED_EN_BIT];
    pump_ctrl.offset_current_polarity = bleed_hi_q[PLDC_OFFSET_CURRENT_POLARITY_BIT];
    pump_ctrl.bleed_coarse            = bleed_code[12:PLDC_BLEED_FINE_W];
    pump_ctrl.bleed_fine              = bleed_code[PLDC_BLEED_FINE_W-1:0];
  end

  always_comb
  begin
    ref_ctrl.ref_doubler_enable = ref_div_q[PLDC_DBL_BIT];
    // Ratio zero is outside the legal range and runs as one
    ref_ctrl.ref_divide_ratio   = (ref_div_q[5:0] == 6'h00) ? PLDC_RDIV_MIN : ref_div_q[5:0];
    ref_ctrl.ref_lowpass_select = ref_cond_q[PLDC_LPF_BIT];
    ref_ctrl.ref_gain_boost     = ref_cond_q[PLDC_BOOST_BIT];
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  lock_off_disabled_a: assert property (
    !det_enable |=> !lock_q && lock_cnt_q == 21'h00_0000)
    else $error("lock active while detector disabled");

  status_lock_mirror_a: assert property (
    psel && !pwrite && reg_idx == PLDC_IDX_STATUS && paddr[1:0] == 2'b00
      |-> prdata[PLDC_ST_LOCK_BIT] == lock_indicator_pin)
    else $error("status lock bit differs from pin");

  test_output_select_lock_a: assert property (
    test_out_q[7:4] == PLDC_MUX_LOCK && $stable(test_out_q) |=> test_output_pin == $past(lock_q))
    else $error("test output does not carry lock");

  lock_needs_count_a: assert property (
    $rose(lock_q) |-> lock_cnt_q >= $past(lock_target) && $past(good_cycle))
    else $error("lock rose before count reached");

  count_keeps_low_a: assert property (
    det_enable && !lock_q && good_cycle && !bad_cycle
      && 21'(lock_cnt_q + 21'h00_0001) < lock_target
      |=> !lock_q && lock_cnt_q == $past(lock_cnt_q) + 21'h00_0001)
    else $error("count did not advance or lock rose early");

  drop_on_bad_a: assert property (
    bad_cycle |=> !lock_q && lock_cnt_q == 21'h00_0000 && !lock_indicator_pin)
    else $error("lock or counter kept after window exceeded");

  window_limit_a: assert property (
    (ph_state_q == PLDC_PH_REF_LEAD || ph_state_q == PLDC_PH_FB_LEAD) && ph_cnt_q < win_cycles
      |-> !bad_cycle || ref_edge || fb_edge)
    else $error("window exceeded early");

  refok_hyst_a: assert property (
    ref_ok_q && sync2_q[3] && !sync2_q[2] |=> ref_ok_q)
    else $error("reference flag dropped inside hysteresis band");

  pump_force_a: assert property (
    test_out_q[2:0] == 3'b110 |-> pump_ctrl.mode == PLDC_PUMP_SOURCE ##0
      pump_ctrl.current_code == pump_cur_q[3:0])
    else $error("pump not forced to source");

  bleed_split_a: assert property (
    pump_ctrl.bleed_coarse == bleed_hi_q[4:1] && pump_ctrl.bleed_fine == {bleed_hi_q[0], bleed_lo_q})
    else $error("bleed code split wrong");

endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the lock detect and pump control block
`timescale 1ns/10ps
module tb_top
  import pldc_pkg::*;
;
  function automatic logic [31:0][20:0] small_tab();
    logic [31:0][20:0] t;
    for (int i = 0; i < 32; i++)
    begin
      t[i] = 21'(i + 4);
    end
    return t;
  endfunction
  // Short counts keep the run brief; every expectation uses this table
  localparam logic [31:0][20:0] LOCK_TAB = small_tab();
  localparam int                CEILING  = 20000;

  logic        core_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ref_side_clock;
  logic        feedback_side_clock;
  logic        ref_peak_above_high;
  logic        ref_peak_above_low;
  logic        lock_indicator_pin;
  logic        test_output_pin;
  pldc_pump_s  pump_ctrl;
  pldc_ref_s   ref_ctrl;
  int          fail_count;
  int          samples_checked;
  int          cycles;
  logic [31:0] rd;
  logic        err;

  pldc_lock_detect #(.LOCK_CYCLES_TAB(LOCK_TAB), .WIN_CYCLES_TAB(PLDC_WIN_CYCLES_DEF)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_side_clock(ref_side_clock),
    .feedback_side_clock(feedback_side_clock), .ref_peak_above_high(ref_peak_above_high),
    .ref_peak_above_low(ref_peak_above_low), .lock_indicator_pin(lock_indicator_pin),
    .test_output_pin(test_output_pin), .pump_ctrl(pump_ctrl), .ref_ctrl(ref_ctrl));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hang counts as a mismatch and goes to the closing report
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == CEILING)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; checks afterwards happen on the falling edge, once outputs settle
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic pulses(input int n, input int skew);
    repeat (n)
    begin
      @(posedge core_clk);
      ref_side_clock <= 1'b1;
      feedback_side_clock <= (skew == 0);
      if (skew > 0)
      begin
        repeat (skew) @(posedge core_clk);
        feedback_side_clock <= 1'b1;
      end
      repeat (8) @(posedge core_clk);
      ref_side_clock <= 1'b0;
      feedback_side_clock <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
    @(negedge core_clk);
  endtask

  task automatic test_regs();
    logic [9:0] idx [9] = '{10'h002, 10'h01D, 10'h01E, 10'h01F, 10'h020, 10'h02C, 10'h02D,
                            10'h02E, 10'h02F};
    logic [7:0] msk [9] = '{8'hE0, 8'hFF, 8'h7F, 8'h0F, 8'h7F, 8'h1F, 8'h30, 8'hF7, 8'hC0};
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, idx[i], 32'h0000_0000);
      chk("reset value", rd, 32'h0000_0000);
      apb(1'b1, idx[i], 32'h0000_00FF);
      apb(1'b0, idx[i], 32'h0000_0000);
      chk("readback", rd & {24'h00_0000, msk[i]}, {24'h00_0000, msk[i]});
      chk("no error", {31'h0, err}, 32'h0000_0000);
    end
    apb(1'b1, 10'h003, 32'h0000_00FF);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    apb(1'b1, PLDC_IDX_STATUS, 32'h0000_00FF);
    chk("status write error", {31'h0, err}, 32'h0000_0001);
  endtask

  task automatic test_pump();
    logic [7:0]      tv [6] = '{8'h00, 8'h04, 8'h06, 8'h05, 8'h07, 8'h02};
    pldc_pump_mode_e tm [6] = '{PLDC_PUMP_NORMAL, PLDC_PUMP_HIZ, PLDC_PUMP_SOURCE,
                                PLDC_PUMP_SINK, PLDC_PUMP_HIZ, PLDC_PUMP_NORMAL};
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, PLDC_IDX_PUMP_CUR, 32'(i));
      chk("pump code", 32'(pump_ctrl.current_code), 32'(i));
    end
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, PLDC_IDX_TEST_OUT, 32'(tv[i]));
      chk("pump mode", 32'(pump_ctrl.mode), 32'(tm[i]));
    end
    apb(1'b1, PLDC_IDX_BLEED_LO, 32'h0000_0034);
    apb(1'b1, PLDC_IDX_BLEED_HI, 32'h0000_006B);
    chk("bleed coarse", 32'(pump_ctrl.bleed_coarse), 32'h0000_0005);
    chk("bleed fine", 32'(pump_ctrl.bleed_fine), 32'h0000_0134);
    chk("bleed en pol", {30'h0, pump_ctrl.bleed_enable, pump_ctrl.offset_current_polarity},
        32'h0000_0003);
    apb(1'b1, PLDC_IDX_BLEED_HI, 32'h0000_0020);
    chk("bleed sink", 32'(pump_ctrl.offset_current_polarity), 32'h0000_0000);
    apb(1'b1, PLDC_IDX_REF_DIV, 32'h0000_006A);
    chk("doubler ratio", 32'({ref_ctrl.ref_doubler_enable, ref_ctrl.ref_divide_ratio}),
        32'h0000_006A);
    apb(1'b1, PLDC_IDX_REF_DIV, 32'h0000_003F);
    chk("ratio max", 32'({ref_ctrl.ref_doubler_enable, ref_ctrl.ref_divide_ratio}),
        32'h0000_003F);
    apb(1'b1, PLDC_IDX_REF_DIV, 32'h0000_0000);
    chk("ratio zero", 32'(ref_ctrl.ref_divide_ratio), 32'(PLDC_RDIV_MIN));
    // Low level square reference: boost on, lowpass off
    apb(1'b1, PLDC_IDX_REF_COND, 32'h0000_0080);
    chk("gain boost", 32'({ref_ctrl.ref_lowpass_select, ref_ctrl.ref_gain_boost}),
        32'h0000_0001);
    // Slow strong sine: lowpass on, boost off
    apb(1'b1, PLDC_IDX_REF_COND, 32'h0000_0040);
    chk("ref lowpass", 32'({ref_ctrl.ref_lowpass_select, ref_ctrl.ref_gain_boost}),
        32'h0000_0002);
  endtask

  task automatic test_refok();
    logic [1:0] hl [4] = '{2'b11, 2'b01, 2'b00, 2'b01};
    logic [31:0] ex [4] = '{32'h8, 32'h8, 32'h0, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      {ref_peak_above_high, ref_peak_above_low} <= hl[i];
      repeat (6) @(posedge core_clk);
      apb(1'b0, PLDC_IDX_STATUS, 32'h0000_0000);
      chk("ref present", rd & 32'h0000_0008, ex[i]);
    end
  endtask

  task automatic test_lock();
    int n0;
    int n3;
    n0 = int'(LOCK_TAB[0]);
    n3 = int'(LOCK_TAB[3]);
    apb(1'b1, PLDC_IDX_WIN_WIDTH, 32'h0000_0000);
    apb(1'b1, PLDC_IDX_LOCK_COUNT, 32'h0000_0000);
    apb(1'b1, PLDC_IDX_TEST_OUT, 32'h0000_0010);
    // Bleed off keeps the static offset well inside any window
    apb(1'b1, PLDC_IDX_BLEED_HI, 32'h0000_0000);
    apb(1'b1, PLDC_IDX_LOCK_EN, 32'h0000_0020);
    pulses(n0 + 2, 0);
    chk("lock one enable", 32'(lock_indicator_pin), 32'h0);
    apb(1'b1, PLDC_IDX_LOCK_EN, 32'h0000_0030);
    pulses(n0 - 1, 0);
    chk("lock before count", 32'(lock_indicator_pin), 32'h0);
    pulses(1, 0);
    chk("lock at count", 32'(lock_indicator_pin), 32'h1);
    chk("test pin lock", 32'(test_output_pin), 32'h1);
    apb(1'b0, PLDC_IDX_STATUS, 32'h0000_0000);
    chk("status lock", rd & 32'h0000_0001, 32'h1);
    apb(1'b1, PLDC_IDX_WIN_WIDTH, 32'h0000_00E0);
    pulses(1, 5);
    chk("lock wide window", 32'(lock_indicator_pin), 32'h1);
    apb(1'b1, PLDC_IDX_WIN_WIDTH, 32'h0000_0000);
    pulses(1, 5);
    chk("lock outside window", 32'(lock_indicator_pin), 32'h0);
    chk("test pin unlock", 32'(test_output_pin), 32'h0);
    apb(1'b1, PLDC_IDX_LOCK_COUNT, 32'h0000_0003);
    pulses(n3 - 1, 0);
    chk("relock early", 32'(lock_indicator_pin), 32'h0);
    pulses(1, 0);
    chk("relock count", 32'(lock_indicator_pin), 32'h1);
    apb(1'b1, PLDC_IDX_TEST_OUT, 32'h0000_0000);
    @(negedge core_clk);
    chk("test pin other", 32'(test_output_pin), 32'h0);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ref_side_clock, feedback_side_clock, ref_peak_above_high, ref_peak_above_low} = '0;
    fail_count = 0;
    samples_checked = 0;
    resetn = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    test_regs();
    test_pump();
    test_refok();
    test_lock();
    finish_test();
  end
endmodule
